/* File: rtl/mss_sequencer.v */
/*
  Major state sequencer for an 18-bit word processor: instruction class
  decode, fetch/defer/execute/break stepping, memory strobes placed by the
  timing phases, data break and program interrupt breaks.
  Assumes a core memory that returns the addressed word on mem_rdata by the
  start of the third phase while mem_rd_q is high, and that writes
  mem_wdata_q back while mem_wr_q is high. The arithmetic element, I/O
  devices and console are outside and act on the strobes given here.
*/
// How it works
// - opcode taken from word bits 0-3 picks instruction class
// - non-jump direct memory reference: fetch cycle then execute cycle
// - direct jump finishes in fetch, loads new address, no memory operand
// - indirect: jump takes two cycles, other memory references take three
// - augmented instructions decode bits 4-17 as extensions, finish in one cycle
// - codes 64, 70, 74 octal select arithmetic, I/O transfer, operate
// - exactly one of four major states each cycle; break only by request
// - program counter increments by one after instruction word read
// - one-cycle instruction runs late in fetch; two-cycle goes to defer/execute
// - indirect bit set: defer reads operand address, execute follows except for jump
// - execute only for memory reference; loads operand, runs held opcode
// - break entered only at instruction completion
// - data break moves one word, then sequencing resumes where it stopped
// - program interrupt stores counter and link at 0000, resumes at 0001
// - seven timing phases in fixed order each cycle
// - each phase gives narrow 40 ns and wide 80 ns pulse (70 ns rounded up to whole clocks)
// - memory read between second and third phase, write from fourth to end
// - sixteen codes: thirteen memory reference, three augmented
// - I/O transfer addresses 64 devices with up to three command pulses
// - every cycle reads addressed word and writes it back, except data break into memory and interrupt, which write their own word
`timescale 1ns/1ps
`include "mss_consts.vh"

module mss_sequencer #(
  parameter PHASE_CYC = `MSS_PHASE_CYC,
  parameter NARROW_CYC = `MSS_NARROW_CYC,
  parameter WIDE_CYC = `MSS_WIDE_CYC
) (
  input wire clk,
  input wire rst,
  input wire [`MSS_WORD_W-1:0] mem_rdata,
  input wire data_brk_req,
  input wire data_brk_to_mem,
  input wire [`MSS_ADDR_W-1:0] data_brk_addr,
  input wire [`MSS_WORD_W-1:0] data_brk_wdata,
  input wire prog_int_req,
  input wire link_bit,
  output reg [`MSS_ADDR_W-1:0] memory_address_register_q,
  output reg mem_rd_q,
  output reg mem_wr_q,
  output reg [`MSS_WORD_W-1:0] mem_wdata_q,
  output reg [`MSS_WORD_W-1:0] memory_buffer_register_q,
  output reg [3:0] instruction_register_q,
  output reg [`MSS_ADDR_W-1:0] program_counter_q,
  output reg [1:0] major_state_q,
  output reg exec_strobe_q,
  output reg eae_strobe_q,
  output reg operate_command_q,
  output reg [13:0] aug_ext_q,
  output reg [`MSS_IOT_DEV_W-1:0] io_device_q,
  output reg [`MSS_IOT_PULSES-1:0] io_pulse_q,
  output reg data_brk_ack_q,
  output reg [`MSS_WORD_W-1:0] data_brk_rdata_q,
  output reg prog_int_ack_q,
  output wire [2:0] timing_phase_q,
  output wire [6:0] phase_narrow_q,
  output wire [6:0] phase_wide_q
);

  // ========================================================================
  // states
  localparam ST_FETCH = 2'h0;
  localparam ST_DEFER = 2'h1;
  localparam ST_EXEC = 2'h2;
  localparam ST_BREAK = 2'h3;

  localparam PH_T1 = 3'h0;
  localparam PH_T2 = 3'h1;
  localparam PH_T3 = 3'h2;
  localparam PH_T4 = 3'h3;
  localparam PH_T5 = 3'h4;
  localparam PH_T6 = 3'h5;
  localparam PH_T7 = 3'h6;

  // ========================================================================
  // decode helpers
  // codes up to the jump code are the thirteen memory reference ones (incl. jump)
  function is_memref;
    input [3:0] op;
    begin
      is_memref = (op <= `MSS_OP_JMP);
    end
  endfunction

  function is_jump;
    input [3:0] op;
    begin
      is_jump = (op == `MSS_OP_JMP);
    end
  endfunction

  // ========================================================================
  // timing phases
  wire [2:0] phase;
  wire phase_start;
  wire cycle_end;

  mss_timing #(
    .PHASE_CYC(PHASE_CYC),
    .NARROW_CYC(NARROW_CYC),
    .WIDE_CYC(WIDE_CYC)
  ) u_timing (
    .clk(clk),
    .rst(rst),
    .phase_q(phase),
    .phase_start_q(phase_start),
    .cycle_end_q(cycle_end),
    .narrow_q(phase_narrow_q),
    .wide_q(phase_wide_q)
  );

  assign timing_phase_q = phase;

  // ========================================================================
  // working state
  reg brk_is_data_q;
  reg brk_to_mem_q;
  reg indirect_q;
  reg [13:0] ext_q;

  wire at_t2 = phase_start && (phase == PH_T2);
  wire at_t3 = phase_start && (phase == PH_T3);
  wire at_t4 = phase_start && (phase == PH_T4);
  wire at_t5 = phase_start && (phase == PH_T5);

  wire [3:0] op_now = instruction_register_q;
  wire [`MSS_ADDR_W-1:0] mb_addr = memory_buffer_register_q[`MSS_ADDR_MSB:0];

  // next major state and address decided at the end of a cycle
  reg [1:0] state_d;
  reg [`MSS_ADDR_W-1:0] ma_d;
  reg boundary;
  reg take_data_brk;
  reg take_prog_int;

  always @* begin
    state_d = ST_FETCH;
    ma_d = program_counter_q;
    boundary = 1'b0;
    case (major_state_q)
      ST_FETCH: begin
        if (is_memref(op_now) && indirect_q) begin
          state_d = ST_DEFER;
          ma_d = mb_addr;
        end else if (is_memref(op_now) && !is_jump(op_now)) begin
          state_d = ST_EXEC;
          ma_d = mb_addr;
        end else begin
          boundary = 1'b1;
        end
      end
      ST_DEFER: begin
        if (is_jump(op_now)) begin
          boundary = 1'b1;
        end else begin
          state_d = ST_EXEC;
          ma_d = mb_addr;
        end
      end
      ST_EXEC: begin
        boundary = 1'b1;
      end
      ST_BREAK: begin
        boundary = 1'b1;
      end
      default: begin
        boundary = 1'b1;
      end
    endcase
    take_data_brk = boundary && data_brk_req;
    take_prog_int = boundary && !data_brk_req && prog_int_req;
    if (take_data_brk) begin
      state_d = ST_BREAK;
      ma_d = data_brk_addr;
    end else if (take_prog_int) begin
      state_d = ST_BREAK;
      ma_d = `MSS_INT_SAVE_ADDR;
    end
  end

  // ========================================================================
  // sequencing and memory strobes
  // a single state register encodes the major state, so only one can be active
  always @(posedge clk) begin
    if (rst) begin
      major_state_q <= ST_FETCH;
      memory_address_register_q <= {`MSS_ADDR_W{1'b0}};
      program_counter_q <= {`MSS_ADDR_W{1'b0}};
      memory_buffer_register_q <= {`MSS_WORD_W{1'b0}};
      instruction_register_q <= 4'h0;
      indirect_q <= 1'b0;
      ext_q <= 14'h0000;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= {`MSS_WORD_W{1'b0}};
      brk_is_data_q <= 1'b0;
      brk_to_mem_q <= 1'b0;
      data_brk_rdata_q <= {`MSS_WORD_W{1'b0}};
    end else begin
      if (at_t2) begin
        mem_rd_q <= 1'b1;
      end
      if (at_t3) begin
        mem_rd_q <= 1'b0;
        memory_buffer_register_q <= mem_rdata;
        case (major_state_q)
          ST_FETCH: begin
            instruction_register_q <= mem_rdata[`MSS_OP_MSB:`MSS_OP_LSB];
            indirect_q <= mem_rdata[`MSS_IND_BIT];
            ext_q <= mem_rdata[`MSS_EXT_MSB:0];
          end
          ST_BREAK: begin
            if (brk_is_data_q) begin
              data_brk_rdata_q <= mem_rdata;
              if (brk_to_mem_q) begin
                memory_buffer_register_q <= data_brk_wdata;
              end
            end else begin
              memory_buffer_register_q <= {link_bit, 4'h0, program_counter_q};
            end
          end
          default: begin
          end
        endcase
      end
      if (at_t4) begin
        mem_wr_q <= 1'b1;
        mem_wdata_q <= memory_buffer_register_q;
        if (major_state_q == ST_FETCH) begin
          program_counter_q <= program_counter_q + 13'h0001;
        end
      end
      if (at_t5) begin
        // jump lands after the fetch increment so it wins over it
        if (is_jump(op_now) && !indirect_q && major_state_q == ST_FETCH) begin
          program_counter_q <= mb_addr;
        end
        if (is_jump(op_now) && major_state_q == ST_DEFER) begin
          program_counter_q <= mb_addr;
        end
        if (major_state_q == ST_BREAK && !brk_is_data_q) begin
          program_counter_q <= `MSS_INT_RESUME_ADDR;
        end
      end
      if (cycle_end) begin
        mem_wr_q <= 1'b0;
        major_state_q <= state_d;
        memory_address_register_q <= ma_d;
        if (take_data_brk) begin
          brk_is_data_q <= 1'b1;
          brk_to_mem_q <= data_brk_to_mem;
        end else if (take_prog_int) begin
          brk_is_data_q <= 1'b0;
          brk_to_mem_q <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // operation strobes toward the processing units
  always @(posedge clk) begin
    if (rst) begin
      exec_strobe_q <= 1'b0;
      eae_strobe_q <= 1'b0;
      operate_command_q <= 1'b0;
      aug_ext_q <= 14'h0000;
      io_device_q <= {`MSS_IOT_DEV_W{1'b0}};
      io_pulse_q <= {`MSS_IOT_PULSES{1'b0}};
      data_brk_ack_q <= 1'b0;
      prog_int_ack_q <= 1'b0;
    end else begin
      exec_strobe_q <= at_t5 && (major_state_q == ST_EXEC);
      eae_strobe_q <= at_t5 && (major_state_q == ST_FETCH) && (op_now == `MSS_OP_EAE);
      operate_command_q <= at_t5 && (major_state_q == ST_FETCH) &&
                           (op_now == `MSS_OP_OPR);
      if (at_t5 && major_state_q == ST_FETCH && !is_memref(op_now)) begin
        aug_ext_q <= ext_q;
      end
      if (at_t3 && major_state_q == ST_FETCH &&
          mem_rdata[`MSS_OP_MSB:`MSS_OP_LSB] == `MSS_OP_IOT) begin
        io_device_q <= mem_rdata[`MSS_IOT_DEV_MSB:`MSS_IOT_DEV_LSB];
      end
      // one command pulse per late phase, each gated by its own word bit
      io_pulse_q <= {`MSS_IOT_PULSES{1'b0}};
      if (phase_start && major_state_q == ST_FETCH && op_now == `MSS_OP_IOT) begin
        case (phase)
          PH_T5: io_pulse_q[0] <= ext_q[2];
          PH_T6: io_pulse_q[1] <= ext_q[1];
          PH_T7: io_pulse_q[2] <= ext_q[0];
          default: io_pulse_q <= {`MSS_IOT_PULSES{1'b0}};
        endcase
      end
      data_brk_ack_q <= cycle_end && (major_state_q == ST_BREAK) && brk_is_data_q;
      prog_int_ack_q <= cycle_end && (major_state_q == ST_BREAK) && !brk_is_data_q;
    end
  end

endmodule

/* File: rtl/mss_consts.vh */
/*
  Shared constants of the major state sequencer: word fields, operation codes,
  fixed break addresses and the timing counts of one computer cycle.
  Assumes a single 50 MHz clock. Word bit 0 is the most significant bit and
  sits at vector index 17.
*/
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH

// ==========================================================================
// word layout
`define MSS_WORD_W 18
`define MSS_ADDR_W 13
`define MSS_OP_MSB 17
`define MSS_OP_LSB 14
`define MSS_IND_BIT 13
`define MSS_ADDR_MSB 12
`define MSS_EXT_MSB 13
`define MSS_IOT_DEV_MSB 11
`define MSS_IOT_DEV_LSB 6
`define MSS_IOT_DEV_W 6
`define MSS_IOT_PULSES 3

// ==========================================================================
// operation codes (word bits 0-3)
`define MSS_OP_JMP 4'hC
`define MSS_OP_EAE 4'hD
`define MSS_OP_IOT 4'hE
`define MSS_OP_OPR 4'hF

// ==========================================================================
// program interrupt locations
`define MSS_INT_SAVE_ADDR 13'h0000
`define MSS_INT_RESUME_ADDR 13'h0001

// ==========================================================================
// timing
`define MSS_CLK_NS 20
`define MSS_CYCLE_NS 1750
`define MSS_NUM_PHASES 7
`define MSS_NARROW_NS 40
`define MSS_WIDE_NS 70
`define MSS_PHASE_CYC ((`MSS_CYCLE_NS / `MSS_NUM_PHASES) / `MSS_CLK_NS)
`define MSS_NARROW_CYC ((`MSS_NARROW_NS + `MSS_CLK_NS - 1) / `MSS_CLK_NS)
`define MSS_WIDE_CYC ((`MSS_WIDE_NS + `MSS_CLK_NS - 1) / `MSS_CLK_NS)

`endif

/* File: rtl/mss_timing.v */
/*
  Timing phase generator: seven phases per computer cycle, each phase with a
  narrow and a wide pulse starting on its first clock.
  Assumes a synchronous active-high reset and one free-running clock.
*/
`timescale 1ns/1ps
`include "mss_consts.vh"

module mss_timing #(
  parameter PHASE_CYC = `MSS_PHASE_CYC,
  parameter NARROW_CYC = `MSS_NARROW_CYC,
  parameter WIDE_CYC = `MSS_WIDE_CYC
) (
  input wire clk,
  input wire rst,
  output reg [2:0] phase_q,
  output reg phase_start_q,
  output reg cycle_end_q,
  output reg [6:0] narrow_q,
  output reg [6:0] wide_q
);

  // ========================================================================
  // phase counters
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg [2:0] phase_d;
  reg [2:0] cnt_phase_q;

  function [6:0] onehot;
    input [2:0] p;
    begin
      onehot = 7'h01 << p;
    end
  endfunction

  always @* begin
    cnt_d = cnt_q + 8'h01;
    phase_d = cnt_phase_q;
    if (cnt_q == PHASE_CYC[7:0] - 8'h01) begin
      cnt_d = 8'h00;
      phase_d = (cnt_phase_q == 3'h6) ? 3'h0 : cnt_phase_q + 3'h1;
    end
  end

  // strobes are registered from the next count so they line up with phase_q
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= PHASE_CYC[7:0] - 8'h01;
      cnt_phase_q <= 3'h6;
      phase_q <= 3'h6;
      phase_start_q <= 1'b0;
      cycle_end_q <= 1'b0;
      narrow_q <= 7'h00;
      wide_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
      cnt_phase_q <= phase_d;
      phase_q <= phase_d;
      phase_start_q <= (cnt_d == 8'h00);
      cycle_end_q <= (phase_d == 3'h6) && (cnt_d == PHASE_CYC[7:0] - 8'h01);
      narrow_q <= (cnt_d < NARROW_CYC[7:0]) ? onehot(phase_d) : 7'h00;
      wide_q <= (cnt_d < WIDE_CYC[7:0]) ? onehot(phase_d) : 7'h00;
    end
  end

endmodule

/* File: tb/mss_seq_monitor.sv */
/*
  Checker of the sequencer ports: phase order, pulse widths, memory strobes
  and the causes of state changes and strobes.
  Assumes it is bound into mss_sequencer and shares its clock and reset.
*/
`timescale 1ns/1ps
`include "mss_consts.vh"

module mss_seq_monitor #(
  parameter PHASE_CYC = `MSS_PHASE_CYC
) (
  input wire clk,
  input wire rst,
  input wire [12:0] memory_address_register_q,
  input wire mem_rd_q,
  input wire mem_wr_q,
  input wire [17:0] memory_buffer_register_q,
  input wire [3:0] instruction_register_q,
  input wire [12:0] program_counter_q,
  input wire [1:0] major_state_q,
  input wire eae_strobe_q,
  input wire operate_command_q,
  input wire [2:0] io_pulse_q,
  input wire data_brk_ack_q,
  input wire prog_int_ack_q,
  input wire [2:0] timing_phase_q,
  input wire [6:0] phase_narrow_q
);
  // write rises one clock into the fourth phase and drops after the cycle's last clock
  localparam int WR_CYC = 4 * PHASE_CYC - 1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========
  // timing
  property p_rd_len; $rose(mem_rd_q) |-> ##PHASE_CYC $fell(mem_rd_q); endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe width");
  property p_rd_ph; mem_rd_q |-> timing_phase_q == 3'h1 || $past(timing_phase_q) == 3'h1;
  endproperty
  a_rd_ph: assert property (p_rd_ph) else $error("read outside second phase");
  property p_wr_gap; $fell(mem_rd_q) |-> ##PHASE_CYC $rose(mem_wr_q); endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write not at fourth phase");
  property p_wr_len; $rose(mem_wr_q) |-> ##WR_CYC $fell(mem_wr_q); endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe width");
  property p_ph_ord;
    timing_phase_q != $past(timing_phase_q) |-> timing_phase_q ==
      (($past(timing_phase_q) == 3'h6) ? 3'h0 : $past(timing_phase_q) + 3'h1);
  endproperty
  a_ph_ord: assert property (p_ph_ord) else $error("phase order");
  property p_nar; $rose(|phase_narrow_q) |-> (|phase_narrow_q) [*2] ##1 !(|phase_narrow_q);
  endproperty
  a_nar: assert property (p_nar) else $error("narrow pulse width");
  property p_nar_ph; |phase_narrow_q |-> phase_narrow_q == (7'h01 << timing_phase_q);
  endproperty
  a_nar_ph: assert property (p_nar_ph) else $error("narrow pulse phase");

  // ==========
  // states and strobes
  property p_st_chg; major_state_q != $past(major_state_q) |->
    timing_phase_q == 3'h0 && $past(timing_phase_q) == 3'h6;
  endproperty
  a_st_chg: assert property (p_st_chg) else $error("state change mid cycle");
  property p_ma_chg; memory_address_register_q != $past(memory_address_register_q) |->
    timing_phase_q == 3'h0;
  endproperty
  a_ma_chg: assert property (p_ma_chg) else $error("address change mid cycle");
  property p_memref; major_state_q == 2'h1 || major_state_q == 2'h2 |->
    instruction_register_q <= `MSS_OP_JMP;
  endproperty
  a_memref: assert property (p_memref) else $error("defer or execute off class");
  property p_aug; eae_strobe_q || operate_command_q |-> major_state_q == 2'h0 &&
    instruction_register_q == (eae_strobe_q ? `MSS_OP_EAE : `MSS_OP_OPR);
  endproperty
  a_aug: assert property (p_aug) else $error("augmented strobe cause");
  property p_iot; io_pulse_q[0] |->
    instruction_register_q == `MSS_OP_IOT && memory_buffer_register_q[2];
  endproperty
  a_iot: assert property (p_iot) else $error("command pulse cause");
  property p_int; prog_int_ack_q |->
    program_counter_q == `MSS_INT_RESUME_ADDR && !data_brk_ack_q;
  endproperty
  a_int: assert property (p_int) else $error("interrupt resume address");
  c_defer: cover property (major_state_q == 2'h1);
  c_dbrk: cover property (data_brk_ack_q);
  c_int: cover property (prog_int_ack_q);
endmodule

bind mss_sequencer mss_seq_monitor #(.PHASE_CYC(PHASE_CYC)) u_mon (.clk, .rst,
  .memory_address_register_q, .mem_rd_q, .mem_wr_q, .memory_buffer_register_q,
  .instruction_register_q, .program_counter_q, .major_state_q, .eae_strobe_q,
  .operate_command_q, .io_pulse_q, .data_brk_ack_q, .prog_int_ack_q,
  .timing_phase_q, .phase_narrow_q);

/* File: tb/mss_mem_model.sv */
/*
  Core memory model: 8K words, read while the read strobe stands, write
  while the write strobe stands. Assumes the bench preloads m directly.
*/
`timescale 1ns/1ps

module mss_mem_model (
  input wire clk,
  input wire [12:0] addr,
  input wire rd,
  input wire wr,
  input wire [17:0] wdata,
  output logic [17:0] rdata
);
  logic [17:0] m [0:8191];
  logic [17:0] last_q = 18'h0;
  always @(posedge clk) begin
    if (wr) m[addr] <= wdata;
    if (rd) last_q <= m[addr];
  end
  // outside the read window show the inverse, so a late sample never matches
  assign rdata = rd ? m[addr] : ~last_q;
endmodule

/* File: tb/tb_top.sv */
/*
  Bench of the major state sequencer: a random program with corner cases,
  then data and interrupt breaks. Assumes mss_mem_model as core memory.
*/
`timescale 1ns/1ps
`include "mss_consts.vh"

module tb_top;
  typedef struct packed {
    logic [1:0] s; logic [12:0] m; logic [12:0] p; logic [3:0] i; logic [13:0] x;
    logic [2:0] c;
  } mss_ent_t;
  logic clk, rst, data_brk_req, data_brk_to_mem, prog_int_req, link_bit, trk;
  logic [12:0] data_brk_addr;
  logic [17:0] data_brk_wdata, mem_rdata, rw;
  logic [2:0] lastp;
  wire [12:0] memory_address_register_q, program_counter_q;
  wire mem_rd_q, mem_wr_q, exec_strobe_q, eae_strobe_q, operate_command_q;
  wire data_brk_ack_q, prog_int_ack_q;
  wire [17:0] mem_wdata_q, memory_buffer_register_q, data_brk_rdata_q;
  wire [3:0] instruction_register_q;
  wire [1:0] major_state_q;
  wire [13:0] aug_ext_q;
  wire [5:0] io_device_q;
  wire [2:0] io_pulse_q, timing_phase_q;
  wire [6:0] phase_narrow_q, phase_wide_q;
  int seed = 32'he169;
  int fails = 0;
  int compares = 0;
  int k;
  mss_ent_t q[$];
  mss_ent_t e;
  logic [3:0] ops [7] = '{4'hC, 4'hC, 4'h0, 4'hB, 4'hD, 4'hE, 4'hF};
  logic inds [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  // short phases keep the run brief; the narrow pulse stays at its real count, the wide one is cut to 3
  mss_sequencer #(.PHASE_CYC(3), .NARROW_CYC(2), .WIDE_CYC(3)) uut (.clk, .rst, .mem_rdata,
    .data_brk_req, .data_brk_to_mem, .data_brk_addr, .data_brk_wdata, .prog_int_req,
    .link_bit, .memory_address_register_q, .mem_rd_q, .mem_wr_q, .mem_wdata_q,
    .memory_buffer_register_q, .instruction_register_q, .program_counter_q,
    .major_state_q, .exec_strobe_q, .eae_strobe_q, .operate_command_q, .aug_ext_q,
    .io_device_q, .io_pulse_q, .data_brk_ack_q, .data_brk_rdata_q, .prog_int_ack_q,
    .timing_phase_q, .phase_narrow_q, .phase_wide_q);
  mss_mem_model mem (.clk(clk), .addr(memory_address_register_q), .rd(mem_rd_q),
    .wr(mem_wr_q), .wdata(mem_wdata_q), .rdata(mem_rdata));

  // ==========
  // checking
  task automatic chk(input logic [17:0] g, input logic [17:0] x);
    compares++;
    if (g !== x) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk) begin
    if (!rst && trk && timing_phase_q === 3'h0 && lastp === 3'h6) begin
      if (q.size() == 0) chk(18'h1, 18'h0);
      else begin
        e = q.pop_front();
        chk(18'(major_state_q), 18'(e.s));
        chk(18'(memory_address_register_q), 18'(e.m));
        if (e.c[2]) chk(18'(program_counter_q), 18'(e.p));
        if (e.c[1]) chk(18'(instruction_register_q), 18'(e.i));
        if (e.c[0]) chk(18'(aug_ext_q), 18'(e.x));
      end
    end
    lastp <= timing_phase_q;
  end

  // ==========
  // stimulus
  task gen;
    logic [12:0] pc, a, t;
    logic [3:0] op;
    logic [17:0] w;
    logic [13:0] px;
    logic ind, pe;
    pc = 13'h0;
    pe = 1'b0;
    px = 14'h0;
    for (int i = 0; i < 13; i++) begin
      op = (i < 7) ? ops[i] : 4'($random(seed));
      ind = (i < 7) ? inds[i] : 1'($random(seed));
      a = (op == 4'hC && !ind) ? pc + 13'h2 : {1'b1, 4'(i), 8'($random(seed))};
      w = {op, ind, a};
      if (op > 4'hC) w[13:0] = 14'($random(seed) | 4);
      q.push_back('{2'h0, pc, pc, 4'h0, px, {2'b10, pe}});
      mem.m[pc] = w;
      px = w[13:0];
      pe = (op > 4'hC);
      if (op <= 4'hC && ind) begin
        mem.m[a] = (op == 4'hC) ? 18'(pc + 13'h2) : 18'({1'b1, 12'($random(seed))});
        q.push_back('{2'h1, a, 13'h0, op, 14'h0, 3'b010});
      end
      t = ind ? mem.m[a][12:0] : a;
      if (op < 4'hC) q.push_back('{2'h2, t, 13'h0, op, 14'h0, 3'b010});
      pc = (op == 4'hC) ? t : pc + 13'h1;
    end
    mem.m[pc] = {4'hC, 1'b0, pc};
    q.push_back('{2'h0, pc, pc, 4'h0, px, {2'b10, pe}});
  endtask
  task rel;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    trk = 1'b1;
  endtask
  task wq;
    for (k = 0; k < 3000 && q.size() != 0; k++) @(negedge clk);
    chk(18'(q.size()), 18'h0);
    trk = 1'b0;
  endtask
  // the request drops once the break state shows: it is sampled again at that cycle's end,
  // so holding it until the ack would buy a second break
  task wd(input logic dat);
    for (k = 0; k < 500 && major_state_q !== 2'h3; k++) @(negedge clk);
    if (dat) data_brk_req = 1'b0;
    else prog_int_req = 1'b0;
    for (k = 0; k < 200 && (dat ? data_brk_ack_q : prog_int_ack_q) !== 1'b1; k++)
      @(negedge clk);
    chk(18'(dat ? data_brk_ack_q : prog_int_ack_q), 18'h1);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    fails++;
    results;
  end
  initial begin
    rst = 1'b1;
    trk = 1'b0;
    data_brk_req = 1'b0;
    data_brk_to_mem = 1'b1;
    data_brk_addr = 13'h1300;
    data_brk_wdata = 18'($random(seed));
    prog_int_req = 1'b0;
    link_bit = 1'($random(seed));
    rw = 18'($random(seed));
    gen;
    rel;
    wq;
    // second reset in mid-run, then a break raised inside a three-cycle instruction
    rst = 1'b1;
    mem.m[0] = {4'h0, 1'b1, 13'h1100};
    mem.m[13'h1100] = 18'h01200;
    mem.m[1] = {4'hC, 1'b0, 13'h0002};
    mem.m[2] = {4'hC, 1'b0, 13'h0002};
    mem.m[13'h1400] = rw;
    q.push_back('{2'h0, 13'h0, 13'h0, 4'h0, 14'h0, 3'b100});
    q.push_back('{2'h1, 13'h1100, 13'h0, 4'h0, 14'h0, 3'b010});
    q.push_back('{2'h2, 13'h1200, 13'h0, 4'h0, 14'h0, 3'b010});
    q.push_back('{2'h3, 13'h1300, 13'h0, 4'h0, 14'h0, 3'b000});
    q.push_back('{2'h0, 13'h1, 13'h1, 4'h0, 14'h0, 3'b100});
    q.push_back('{2'h0, 13'h2, 13'h2, 4'h0, 14'h0, 3'b100});
    rel;
    repeat (5) @(negedge clk);
    data_brk_req = 1'b1;
    wd(1'b1);
    wq;
    chk(mem.m[13'h1300], data_brk_wdata);
    for (k = 0; k < 200 && timing_phase_q !== 3'h2; k++) @(negedge clk);
    q.push_back('{2'h3, 13'h1400, 13'h0, 4'h0, 14'h0, 3'b000});
    q.push_back('{2'h0, 13'h2, 13'h2, 4'h0, 14'h0, 3'b100});
    q.push_back('{2'h3, 13'h0, 13'h0, 4'h0, 14'h0, 3'b000});
    q.push_back('{2'h0, 13'h1, 13'h1, 4'h0, 14'h0, 3'b100});
    q.push_back('{2'h0, 13'h2, 13'h2, 4'h0, 14'h0, 3'b100});
    data_brk_to_mem = 1'b0;
    data_brk_addr = 13'h1400;
    data_brk_req = 1'b1;
    trk = 1'b1;
    wd(1'b1);
    chk(data_brk_rdata_q, rw);
    prog_int_req = 1'b1;
    wd(1'b0);
    wq;
    chk(mem.m[0], {link_bit, 4'h0, 13'h0002});
    results;
  end
endmodule
